// ==== src/fcr_pkg.sv ====
package fcr_pkg;

    // -------------------------------------------------------------------------
    // opcodes: the first six matched on the low five bits of the first byte, the last three on the whole byte
    // -------------------------------------------------------------------------
    localparam logic [7:0] OPC_MASK = 8'h1f;
    localparam logic [7:0] OPC_READ = 8'h06;
    localparam logic [7:0] OPC_WRITE = 8'h05;
    localparam logic [7:0] OPC_VERIFY = 8'h16;
    localparam logic [7:0] OPC_FORMAT = 8'h0d;
    localparam logic [7:0] OPC_SEEK = 8'h0f;
    localparam logic [7:0] OPC_RECAL = 8'h07;
    localparam logic [7:0] OPC_SENSE_INT = 8'h08;
    localparam logic [7:0] OPC_PERP = 8'h12;
    localparam logic [7:0] OPC_SPECIFY = 8'h03;

    typedef enum logic [3:0] {
        FCR_CMD_INVALID = 4'h0,
        FCR_CMD_READ = 4'h1,
        FCR_CMD_WRITE = 4'h2,
        FCR_CMD_VERIFY = 4'h3,
        FCR_CMD_FORMAT = 4'h4,
        FCR_CMD_SEEK = 4'h5,
        FCR_CMD_RECAL = 4'h6,
        FCR_CMD_SENSE_INT = 4'h7,
        FCR_CMD_PERP = 4'h8,
        FCR_CMD_SPECIFY = 4'h9
    } fcr_cmd_t;

    typedef enum logic [1:0] {
        FCR_PH_CMD = 2'b00,
        FCR_PH_PARAM = 2'b01,
        FCR_PH_EXEC = 2'b11,
        FCR_PH_RESULT = 2'b10
    } fcr_phase_t;

    // -------------------------------------------------------------------------
    // byte counts, field positions, values
    // -------------------------------------------------------------------------
    localparam logic [3:0] NPAR_DATA = 4'h8;
    localparam logic [3:0] NPAR_FORMAT = 4'h5;
    localparam logic [3:0] NPAR_SEEK = 4'h2;
    localparam logic [3:0] NPAR_RECAL = 4'h1;
    localparam logic [3:0] NPAR_PERP = 4'h1;
    localparam logic [3:0] NPAR_SPECIFY = 4'h2;
    localparam logic [2:0] NRES_DATA = 3'h7;
    localparam logic [2:0] NRES_SENSE = 3'h2;
    localparam logic [2:0] NRES_INVALID = 3'h1;
    localparam int PAR_DEPTH = 9;
    localparam int RES_DEPTH = 7;
    localparam int IDX_UNIT = 1;
    localparam int IDX_CYL = 2;
    localparam int IDX_FMT_N = 2;
    localparam int IDX_N = 5;
    localparam int IDX_FILL = 5;
    localparam int IDX_DTL = 8;
    localparam int BIT_HEAD = 2;
    localparam int BIT_DIR = 6;
    localparam int BIT_EC = 7;
    localparam int BIT_REL = 7;
    localparam int BIT_PERP_D0 = 2;
    localparam int NUM_DRIVES = 2;
    localparam logic [1:0] DRIVE0_CODE = 2'b00;
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [15:0] SECTOR_BASE = 16'h0080;
    localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// ==== src/fcr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcr_top
    import fcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_request_flag,
    output logic transfer_direction_flag,
    output logic command_busy_flag,
    output logic floppy_interrupt_line,
    output logic exec_start,
    output fcr_cmd_t exec_cmd,
    input wire logic exec_done,
    input wire logic res_wr,
    input wire logic [7:0] res_data,
    input wire logic [7:0] seek_status,
    input wire logic [15:0] byte_index,
    output logic [1:0] drive_select_field,
    output logic drive_valid,
    output logic head_select,
    output logic [7:0] cylinder,
    output logic step_inward,
    output logic relative_seek,
    output logic [NUM_DRIVES-1:0] perpendicular_drive_flags,
    output logic [15:0] sector_bytes,
    output logic [15:0] host_bytes,
    output logic [15:0] crc_bytes,
    output logic pass_to_host,
    output logic zero_fill,
    output logic [7:0] data_length_param,
    output logic enable_count_bit,
    output logic [7:0] sectors_per_track_param,
    output logic [7:0] fill_pattern
);

    // -------------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------------
    function automatic fcr_cmd_t fcr_decode(input logic [7:0] b);
        logic [7:0] op;
        op = b & OPC_MASK;
        if (op == OPC_READ) fcr_decode = FCR_CMD_READ;
        else if (op == OPC_WRITE) fcr_decode = FCR_CMD_WRITE;
        else if (op == OPC_VERIFY) fcr_decode = FCR_CMD_VERIFY;
        else if (op == OPC_FORMAT) fcr_decode = FCR_CMD_FORMAT;
        else if (op == OPC_SEEK) fcr_decode = FCR_CMD_SEEK;
        else if (op == OPC_RECAL) fcr_decode = FCR_CMD_RECAL;
        else if (b == OPC_SENSE_INT) fcr_decode = FCR_CMD_SENSE_INT;
        else if (b == OPC_PERP) fcr_decode = FCR_CMD_PERP;
        else if (b == OPC_SPECIFY) fcr_decode = FCR_CMD_SPECIFY;
        else fcr_decode = FCR_CMD_INVALID;
    endfunction

    function automatic logic [3:0] fcr_npar(input fcr_cmd_t c);
        unique case (c)
            FCR_CMD_READ, FCR_CMD_WRITE, FCR_CMD_VERIFY: fcr_npar = NPAR_DATA;
            FCR_CMD_FORMAT: fcr_npar = NPAR_FORMAT;
            FCR_CMD_SEEK: fcr_npar = NPAR_SEEK;
            FCR_CMD_RECAL: fcr_npar = NPAR_RECAL;
            FCR_CMD_PERP: fcr_npar = NPAR_PERP;
            FCR_CMD_SPECIFY: fcr_npar = NPAR_SPECIFY;
            FCR_CMD_SENSE_INT, FCR_CMD_INVALID: fcr_npar = 4'h0;
        endcase
    endfunction

    // -------------------------------------------------------------------------
    // phase sequencing
    // -------------------------------------------------------------------------
    fcr_phase_t phase, next_phase;
    fcr_cmd_t cur_cmd, dec_cmd;
    logic [7:0] op_byte;
    logic [7:0] param_mem [PAR_DEPTH];
    logic [7:0] res_mem [RES_DEPTH];
    logic [3:0] pcnt;
    logic [2:0] res_total, rd_ptr, res_wptr;
    logic invalid_pend, wr_ok, rd_ok, go_exec, go_sense, go_invalid;
    logic perp_done, exec_int, last_param, last_read, start_q;

    // writes only in command phases, reads only while results stand
    assign wr_ok = host_wr && host_request_flag && !transfer_direction_flag &&
                   (phase == FCR_PH_CMD || phase == FCR_PH_PARAM);
    assign rd_ok = host_rd && host_request_flag && transfer_direction_flag &&
                   phase == FCR_PH_RESULT;
    assign dec_cmd = fcr_decode(host_wdata);
    assign last_param = (pcnt + 4'h1) == fcr_npar(cur_cmd);
    assign last_read = (rd_ptr + 3'h1) == res_total;

    always_comb begin
        next_phase = phase;
        go_exec = 1'b0;
        go_sense = 1'b0;
        go_invalid = 1'b0;
        perp_done = 1'b0;
        exec_int = 1'b0;
        unique case (phase)
            FCR_PH_CMD: begin
                if (wr_ok) begin
                    if (dec_cmd == FCR_CMD_INVALID) begin
                        go_invalid = 1'b1;
                    end else if (dec_cmd == FCR_CMD_SENSE_INT) begin
                        go_sense = 1'b1;
                        next_phase = FCR_PH_RESULT;
                    end else begin
                        next_phase = FCR_PH_PARAM;
                    end
                end
            end
            FCR_PH_PARAM: begin
                if (wr_ok && last_param) begin
                    if (cur_cmd == FCR_CMD_PERP || cur_cmd == FCR_CMD_SPECIFY) begin
                        perp_done = cur_cmd == FCR_CMD_PERP;
                        next_phase = FCR_PH_CMD;
                    end else begin
                        go_exec = 1'b1;
                        next_phase = FCR_PH_EXEC;
                    end
                end
            end
            FCR_PH_EXEC: begin
                if (exec_done) begin
                    exec_int = 1'b1;
                    if (cur_cmd == FCR_CMD_SEEK || cur_cmd == FCR_CMD_RECAL) begin
                        next_phase = FCR_PH_CMD;
                    end else begin
                        next_phase = FCR_PH_RESULT;
                    end
                end
            end
            FCR_PH_RESULT: begin
                // no command is taken until the last result byte is out
                if (rd_ok && last_read) begin
                    next_phase = FCR_PH_CMD;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase <= FCR_PH_CMD;
            cur_cmd <= FCR_CMD_INVALID;
            op_byte <= BYTE_RST;
            pcnt <= 4'h0;
        end else begin
            phase <= next_phase;
            if (phase == FCR_PH_CMD && wr_ok) begin
                cur_cmd <= dec_cmd;
                op_byte <= host_wdata;
                pcnt <= 4'h0;
            end else if (phase == FCR_PH_PARAM && wr_ok) begin
                pcnt <= pcnt + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < PAR_DEPTH; i++) begin
                param_mem[i] <= BYTE_RST;
            end
        end else if (phase == FCR_PH_PARAM && wr_ok) begin
            param_mem[pcnt + 4'h1] <= host_wdata;
        end
    end

    // -------------------------------------------------------------------------
    // result buffer: filled by the engine, or locally for sense interrupt
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < RES_DEPTH; i++) begin
                res_mem[i] <= BYTE_RST;
            end
            res_wptr <= 3'h0;
            res_total <= 3'h0;
            invalid_pend <= 1'b0;
        end else begin
            if (go_invalid) begin
                invalid_pend <= 1'b1;
            end else if (go_sense) begin
                invalid_pend <= 1'b0;
            end
            if (go_sense) begin
                res_mem[0] <= invalid_pend ? ST0_INVALID : seek_status;
                res_mem[1] <= cylinder;
                res_total <= invalid_pend ? NRES_INVALID : NRES_SENSE;
            end else if (go_exec) begin
                res_wptr <= 3'h0;
                res_total <= NRES_DATA;
            end else if (res_wr && phase == FCR_PH_EXEC && res_wptr < NRES_DATA) begin
                res_mem[res_wptr] <= res_data;
                res_wptr <= res_wptr + 3'h1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // host data port and status flags
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_ptr <= 3'h0;
            host_rdata <= BYTE_RST;
        end else if (next_phase == FCR_PH_RESULT && phase != FCR_PH_RESULT) begin
            rd_ptr <= 3'h0;
            host_rdata <= go_sense ? (invalid_pend ? ST0_INVALID : seek_status) : res_mem[0];
        end else if (rd_ok && !last_read) begin
            rd_ptr <= rd_ptr + 3'h1;
            host_rdata <= res_mem[rd_ptr + 3'h1];
        end
    end

    // request drops for one cycle after every accepted byte, and stays low through execution, so the host
    // never sees a stale byte or double-writes before it is processed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            host_request_flag <= 1'b1;
            transfer_direction_flag <= 1'b0;
            command_busy_flag <= 1'b0;
        end else begin
            host_request_flag <= (next_phase != FCR_PH_EXEC) && !wr_ok && !rd_ok;
            transfer_direction_flag <= next_phase == FCR_PH_RESULT;
            command_busy_flag <= next_phase != FCR_PH_CMD;
        end
    end

    // set wins over clear: a new event in the clearing cycle is kept
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            floppy_interrupt_line <= 1'b0;
        end else if (exec_int || go_invalid) begin
            floppy_interrupt_line <= 1'b1;
        end else if (go_sense || rd_ok) begin
            floppy_interrupt_line <= 1'b0;
        end
    end

    // parameters settle one edge after the last byte, so start waits two
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            exec_start <= 1'b0;
            exec_cmd <= FCR_CMD_INVALID;
        end else begin
            start_q <= go_exec;
            exec_start <= start_q;
            exec_cmd <= cur_cmd;
        end
    end

    // -------------------------------------------------------------------------
    // parameter decoding
    // -------------------------------------------------------------------------
    logic [2:0] size_code;
    logic [15:0] sec_len;
    logic [15:0] lim_len;
    logic is_fmt, is_wr;

    assign is_fmt = cur_cmd == FCR_CMD_FORMAT;
    assign is_wr = cur_cmd == FCR_CMD_WRITE || is_fmt;
    assign size_code = is_fmt ? param_mem[IDX_FMT_N][2:0] : param_mem[IDX_N][2:0];
    assign sec_len = SECTOR_BASE << size_code;
    // data length only trims when the size code is zero, else ignored
    assign lim_len = (size_code == 3'h0 && {8'h00, param_mem[IDX_DTL]} < sec_len) ?
                     {8'h00, param_mem[IDX_DTL]} : sec_len;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            drive_select_field <= 2'b00;
            drive_valid <= 1'b1;
            head_select <= 1'b0;
            cylinder <= BYTE_RST;
            step_inward <= 1'b0;
            relative_seek <= 1'b0;
        end else begin
            drive_select_field <= param_mem[IDX_UNIT][1:0];
            drive_valid <= param_mem[IDX_UNIT][1:0] == DRIVE0_CODE;
            head_select <= param_mem[IDX_UNIT][BIT_HEAD];
            cylinder <= param_mem[IDX_CYL];
            step_inward <= op_byte[BIT_DIR];
            relative_seek <= cur_cmd == FCR_CMD_SEEK && op_byte[BIT_REL];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sector_bytes <= SECTOR_BASE;
            host_bytes <= SECTOR_BASE;
            crc_bytes <= SECTOR_BASE;
            pass_to_host <= 1'b0;
            zero_fill <= 1'b0;
        end else begin
            sector_bytes <= sec_len;
            host_bytes <= lim_len;
            crc_bytes <= sec_len;
            pass_to_host <= !is_wr && byte_index < lim_len;
            zero_fill <= is_wr && !is_fmt && byte_index >= lim_len;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_length_param <= BYTE_RST;
            enable_count_bit <= 1'b0;
            sectors_per_track_param <= BYTE_RST;
            fill_pattern <= BYTE_RST;
        end else begin
            data_length_param <= param_mem[IDX_DTL];
            enable_count_bit <= cur_cmd == FCR_CMD_VERIFY && op_byte[BIT_EC];
            if (cur_cmd == FCR_CMD_VERIFY && op_byte[BIT_EC]) begin
                sectors_per_track_param <= param_mem[IDX_DTL];
            end
            fill_pattern <= param_mem[IDX_FILL];
        end
    end

    genvar d;
    generate
        for (d = 0; d < NUM_DRIVES; d++) begin : g_perp
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    perpendicular_drive_flags[d] <= 1'b0;
                end else if (perp_done) begin
                    perpendicular_drive_flags[d] <= host_wdata[BIT_PERP_D0 + d];
                end
            end
        end
    endgenerate

endmodule // fcr_top
`default_nettype wire

// ==== testbench/fcr_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcr_top_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_rdata,
    input wire logic host_request_flag,
    input wire logic transfer_direction_flag,
    input wire logic command_busy_flag,
    input wire logic floppy_interrupt_line,
    input wire logic exec_start,
    input wire logic exec_done,
    input wire logic [15:0] byte_index,
    input wire logic [1:0] drive_select_field,
    input wire logic drive_valid,
    input wire logic [15:0] sector_bytes,
    input wire logic [15:0] host_bytes,
    input wire logic [15:0] crc_bytes,
    input wire logic pass_to_host,
    input wire logic zero_fill
);
    default clocking cb_main @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // handshake flags
    // ------------------------------------------------------------------
    wr_drop_a: assert property (host_wr && host_request_flag && !transfer_direction_flag |=> !host_request_flag)
        else $error("request flag stayed up after a command write");
    rd_gap_a: assert property (host_rd && host_request_flag && transfer_direction_flag
        |=> !host_request_flag ##1 host_request_flag)
        else $error("request flag gap after a result read is wrong");
    last_read_a: assert property ($fell(transfer_direction_flag)
        |-> !command_busy_flag && !host_request_flag ##1 host_request_flag)
        else $error("flags wrong after the final result byte");
    done_int_a: assert property (exec_done && command_busy_flag |=> floppy_interrupt_line && host_request_flag)
        else $error("no interrupt after execution finished");
    refuse_wr_a: assert property (transfer_direction_flag && host_wr && !host_rd
        |=> transfer_direction_flag && $stable(host_rdata))
        else $error("write accepted during result phase");
    exec_quiet_a: assert property (exec_start |-> !host_request_flag && command_busy_flag)
        else $error("execution started while host may still write");

    // ------------------------------------------------------------------
    // decoded parameters
    // ------------------------------------------------------------------
    drive_ok_a: assert property (drive_valid == (drive_select_field == 2'b00))
        else $error("drive valid does not follow drive select");
    size_zero_a: assert property (sector_bytes == 16'h0080 |-> host_bytes <= 16'h0080)
        else $error("short sector moves more than 128 bytes");
    pass_limit_a: assert property (pass_to_host |-> $past(byte_index) < host_bytes)
        else $error("excess byte passed to host");
    fill_limit_a: assert property (zero_fill |-> $past(byte_index) >= host_bytes)
        else $error("zero fill inside the host data");
    crc_full_a: assert property (crc_bytes == sector_bytes)
        else $error("check code length differs from sector length");

    cover property (exec_done);
    cover property ($fell(transfer_direction_flag));
    cover property (zero_fill);
endmodule // fcr_top_asserts

bind fcr_top fcr_top_asserts u_chk (.ref_clk, .rst_n, .host_wr, .host_rd, .host_rdata, .host_request_flag,
    .transfer_direction_flag, .command_busy_flag, .floppy_interrupt_line, .exec_start, .exec_done, .byte_index,
    .drive_select_field, .drive_valid, .sector_bytes, .host_bytes, .crc_bytes, .pass_to_host, .zero_fill);
`default_nettype wire

// ==== testbench/fcr_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcr_engine_model
    import fcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic exec_start,
    input wire fcr_cmd_t exec_cmd,
    output logic res_wr,
    output logic [7:0] res_data,
    output logic exec_done
);
    logic busy;
    logic [5:0] wait_cnt;
    logic [3:0] n_left;

    // result bytes a7 down to a1; data toggles between them to expose stale reads
    always_ff @(posedge ref_clk) begin
        res_wr <= 1'b0;
        exec_done <= 1'b0;
        res_data <= ~res_data;
        if (!rst_n) begin
            busy <= 1'b0;
            wait_cnt <= 6'h00;
            n_left <= 4'h0;
            res_data <= 8'h00;
        end else if (exec_start) begin
            busy <= 1'b1;
            wait_cnt <= slow ? 6'h14 : 6'h01;
            n_left <= (exec_cmd == FCR_CMD_SEEK || exec_cmd == FCR_CMD_RECAL) ? 4'h0 : 4'h7;
        end else if (busy) begin
            if (wait_cnt != 6'h00) begin
                wait_cnt <= wait_cnt - 6'h01;
            end else if (n_left != 4'h0) begin
                res_wr <= 1'b1;
                res_data <= 8'ha0 + {4'h0, n_left};
                n_left <= n_left - 4'h1;
            end else begin
                exec_done <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule // fcr_engine_model
`default_nettype wire

// ==== testbench/tb_floppy_command_result_phase.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_command_result_phase;
    import fcr_pkg::*;
    logic ref_clk, rst_n, host_wr, host_rd, slow, exec_start, exec_done, res_wr;
    logic host_request_flag, transfer_direction_flag, command_busy_flag, floppy_interrupt_line;
    logic drive_valid, head_select, step_inward, relative_seek, pass_to_host, zero_fill, enable_count_bit;
    logic [7:0] host_wdata, host_rdata, res_data, seek_status, cylinder;
    logic [7:0] data_length_param, sectors_per_track_param, fill_pattern;
    logic [1:0] drive_select_field, perpendicular_drive_flags;
    logic [15:0] byte_index, sector_bytes, host_bytes, crc_bytes;
    fcr_cmd_t exec_cmd;
    int checks = 0;
    int n_mismatch = 0;
    int cycles = 0;

    fcr_top dut (.ref_clk, .rst_n, .host_wr, .host_rd, .host_wdata, .host_rdata, .host_request_flag,
        .transfer_direction_flag, .command_busy_flag, .floppy_interrupt_line, .exec_start, .exec_cmd, .exec_done,
        .res_wr, .res_data, .seek_status, .byte_index, .drive_select_field, .drive_valid, .head_select, .cylinder,
        .step_inward, .relative_seek, .perpendicular_drive_flags, .sector_bytes, .host_bytes, .crc_bytes,
        .pass_to_host, .zero_fill, .data_length_param, .enable_count_bit, .sectors_per_track_param, .fill_pattern);
    fcr_engine_model u_engine (.ref_clk, .rst_n, .slow, .exec_start, .exec_cmd, .res_wr, .res_data, .exec_done);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ceiling only catches a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // host access tasks; every step lands 1 ns after a rising edge
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic wait_rqm(input logic dexp);
        int n;
        n = 0;
        while (!(host_request_flag === 1'b1 && transfer_direction_flag === dexp) && n < 300) begin
            tick(1);
            n++;
        end
        chk("flag wait timeout", 16'h0000, {15'h0, n == 300});
    endtask

    task automatic strobe(input logic rd, input logic [7:0] b);
        host_wr = !rd;
        host_rd = rd;
        host_wdata = b;
        tick(1);
        host_wr = 1'b0;
        host_rd = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] b);
        wait_rqm(1'b0);
        strobe(1'b0, b);
        chk("request after write", 16'h0000, {15'h0, host_request_flag});
    endtask

    task automatic rd_byte(input logic [7:0] exp);
        wait_rqm(1'b1);
        chk("result byte", {8'h00, exp}, {8'h00, host_rdata});
        strobe(1'b1, 8'h00);
        chk("request after read", 16'h0000, {15'h0, host_request_flag});
    endtask

    task automatic end_check();
        chk("direction at end", 16'h0000, {15'h0, transfer_direction_flag});
        chk("busy at end", 16'h0000, {15'h0, command_busy_flag});
        tick(1);
        chk("request at end", 16'h0001, {15'h0, host_request_flag});
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] sops[2] = '{8'hcf, 8'h0f};
        logic [7:0] sunit[2] = '{8'h04, 8'h01};
        logic [7:0] scyl[2] = '{8'hff, 8'h12};
        logic [7:0] dops[3] = '{8'h06, 8'h05, 8'h96};
        logic [7:0] dn[3] = '{8'h00, 8'h00, 8'h02};
        logic [7:0] ddtl[3] = '{8'h40, 8'h10, 8'h09};
        logic [15:0] dsec[3] = '{16'h0080, 16'h0080, 16'h0200};
        logic [15:0] dhb[3] = '{16'h0040, 16'h0010, 16'h0200};
        logic [7:0] par[8];
        rst_n = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
        slow = 1'b0;
        byte_index = 16'h0000;
        seek_status = 8'h20;
        tick(20);
        rst_n = 1'b1;
        chk("reset request", 16'h0001, {15'h0, host_request_flag});
        chk("reset sector bytes", 16'h0080, sector_bytes);
        wr_byte(8'h1f);
        chk("invalid interrupt", 16'h0001, {15'h0, floppy_interrupt_line});
        wr_byte(OPC_SENSE_INT);
        rd_byte(ST0_INVALID);
        end_check();
        for (int i = 0; i < 2; i++) begin
            wr_byte(sops[i]);
            wr_byte(sunit[i]);
            wr_byte(scyl[i]);
            tick(2);
            chk("step inward", {15'h0, sops[i][6]}, {15'h0, step_inward});
            chk("relative", {15'h0, sops[i][7]}, {15'h0, relative_seek});
            chk("cylinder", {8'h00, scyl[i]}, {8'h00, cylinder});
            chk("drive select", {14'h0, sunit[i][1:0]}, {14'h0, drive_select_field});
            chk("drive valid", {15'h0, sunit[i][1:0] == 2'b00}, {15'h0, drive_valid});
            chk("head", {15'h0, sunit[i][2]}, {15'h0, head_select});
            wait_rqm(1'b0);
            chk("seek interrupt", 16'h0001, {15'h0, floppy_interrupt_line});
            wr_byte(OPC_SENSE_INT);
            rd_byte(seek_status);
            rd_byte(scyl[i]);
            end_check();
        end
        slow = 1'b1;
        for (int j = 0; j < 3; j++) begin
            par = '{8'h00, 8'h05, 8'h00, 8'h01, dn[j], 8'h09, 8'h1b, ddtl[j]};
            wr_byte(dops[j]);
            for (int k = 0; k < 8; k++) begin
                wr_byte(par[k]);
            end
            tick(2);
            chk("sector bytes", dsec[j], sector_bytes);
            chk("host bytes", dhb[j], host_bytes);
            chk("check bytes", dsec[j], crc_bytes);
            chk("data length", {8'h00, ddtl[j]}, {8'h00, data_length_param});
            chk("count enable", {15'h0, dops[j][7]}, {15'h0, enable_count_bit});
            if (j == 2) begin
                chk("sectors per track", {8'h00, ddtl[j]}, {8'h00, sectors_per_track_param});
            end else begin
                byte_index = dhb[j] - 16'h0001;
                tick(2);
                chk("pass last", {15'h0, j == 0}, {15'h0, pass_to_host});
                chk("fill last", 16'h0000, {15'h0, zero_fill});
                byte_index = dhb[j];
                tick(2);
                chk("pass excess", 16'h0000, {15'h0, pass_to_host});
                chk("fill excess", {15'h0, j == 1}, {15'h0, zero_fill});
            end
            wait_rqm(1'b1);
            chk("data interrupt", 16'h0001, {15'h0, floppy_interrupt_line});
            strobe(1'b0, OPC_READ);
            chk("write refused", 16'h0001, {15'h0, transfer_direction_flag});
            for (int k = 0; k < 7; k++) begin
                rd_byte(8'ha7 - 8'(k));
            end
            end_check();
        end
        slow = 1'b0;
        par[0:4] = '{8'h00, 8'h02, 8'h09, 8'h54, 8'h5a};
        wr_byte(OPC_FORMAT);
        for (int k = 0; k < 5; k++) begin
            wr_byte(par[k]);
        end
        tick(2);
        chk("fill pattern", 16'h005a, {8'h00, fill_pattern});
        for (int k = 0; k < 7; k++) begin
            rd_byte(8'ha7 - 8'(k));
        end
        end_check();
        for (int p = 1; p < 3; p++) begin
            wr_byte(OPC_PERP);
            wr_byte(8'(p << 2));
            wait_rqm(1'b0);
            chk("perpendicular", 16'(p), {14'h0, perpendicular_drive_flags});
        end
        tally_and_finish();
    end
endmodule // tb_floppy_command_result_phase
`default_nettype wire
